// ==== vcr_pkg.sv ====
// Shared constants and carrier types of the video core control bank.
// Assumes a 32-bit register bus and a 24-bit pixel word on the video stream.
package vcr_pkg;
   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [11:0] OFS_CORE_CONTROL = 12'h000;
   localparam logic [11:0] OFS_CORE_STATUS = 12'h004;
   localparam logic [11:0] OFS_STREAM_ERROR_FLAGS = 12'h008;
   localparam logic [11:0] OFS_INTERRUPT_ENABLE_MASK = 12'h00c;
   localparam logic [11:0] OFS_CORE_VERSION_ID = 12'h010;
   localparam logic [11:0] OFS_FRAME_COUNT_MONITOR = 12'h014;
   localparam logic [11:0] OFS_LINE_COUNT_MONITOR = 12'h018;
   localparam logic [11:0] OFS_PIXEL_COUNT_MONITOR = 12'h01c;
   localparam logic [11:0] OFS_FRAME_DIMENSIONS = 12'h020;
   localparam logic [11:0] OFS_TEMPORAL_VARIANCE_THRESHOLD = 12'h100;
   localparam logic [11:0] OFS_SPATIAL_VARIANCE_THRESHOLD = 12'h104;
   localparam logic [11:0] OFS_PIXEL_AGE_THRESHOLD = 12'h108;
   localparam logic [11:0] OFS_CANDIDATE_COUNT = 12'h10c;
   localparam logic [11:0] OFS_DEFECT_COUNT = 12'h120;
   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_COMMIT_BIT = 1;
   localparam int CTRL_FSYNC_RESET_BIT = 29;
   localparam int CTRL_IMM_RESET_BIT = 30;
   localparam int CTRL_AUTO_RESET_BIT = 31;
   localparam int ERR_LINE_SHORT_BIT = 0;
   localparam int ERR_LINE_LONG_BIT = 1;
   localparam int ERR_SOF_EARLY_BIT = 2;
   localparam int ERR_SOF_LATE_BIT = 3;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0002;
   localparam logic [31:0] DIMENSIONS_RESET = 32'h0438_0780;
   localparam logic [31:0] THRESHOLD_RESET = 32'h0000_0000;
   localparam int RESET_HOLD_CYCLES = 32;
   localparam int PIX_W = 24;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // ----------------------------------------------------------------
   // Carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic user;
      logic last;
      logic [PIX_W-1:0] data;
   } vcr_beat_type;
   typedef struct packed {
      logic [31:0] dims;
      logic [2:0][31:0] thr;
   } vcr_params_type;
   localparam vcr_params_type PARAMS_RESET = '{dims: DIMENSIONS_RESET,
      thr: {3{THRESHOLD_RESET}}};
endpackage

// ==== vcr_fifo.sv ====
// Synchronous FIFO with valid and ready on both sides and a flush input.
// Assumes DEPTH is a power of two.
`timescale 1ns/100ps
module vcr_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic flush,
   input wire logic [WIDTH-1:0] inData,
   input wire logic inValid,
   output logic inReady,
   output logic [WIDTH-1:0] outData,
   output logic outValid,
   input wire logic outReady
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int CW = $clog2(DEPTH + 1);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [CW-1:0] cnt;
   } vcr_fifo_state_type;
   vcr_fifo_state_type q_reg, q_next;
   logic push, pop;

   assign inReady = (q_reg.cnt != CW'(DEPTH)) && !flush;
   assign outValid = (q_reg.cnt != '0) && !flush;
   assign outData = q_reg.mem[q_reg.rp];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_comb begin
      q_next = q_reg;
      if (flush) begin
         q_next.wp = '0;
         q_next.rp = '0;
         q_next.cnt = '0;
      end else begin
         if (push) begin
            q_next.mem[q_reg.wp] = inData;
            q_next.wp = q_reg.wp + 1'b1;
         end
         if (pop) begin
            q_next.rp = q_reg.rp + 1'b1;
         end
         q_next.cnt = q_reg.cnt + CW'(push) - CW'(pop);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q_reg <= '0;
      end else begin
         q_reg <= q_next;
      end
   end

   property p_fifo_count;
      @(posedge clk) disable iff (sys_rst)
      (push && !pop && !flush) |=> (q_reg.cnt == $past(q_reg.cnt) + 1'b1);
   endproperty
   a_fifo_count: assert property (p_fifo_count) else $error("fifo count not advanced");
endmodule

// ==== vcr_reset_seq.sv ====
// Sequencer of the immediate, frame-end and frame-start software resets.
// Assumes the request and frame event inputs are single-cycle pulses.
`timescale 1ns/100ps
module vcr_reset_seq (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic immHold,
   input wire logic autoReq,
   input wire logic fsyncReq,
   input wire logic frameStart,
   input wire logic frameEnd,
   input wire logic inFrame,
   output logic coreReset,
   output logic resetPending
);
   import vcr_pkg::*;
   typedef enum logic [3:0] {
      SEQ_IDLE = 4'b0001,
      SEQ_WAIT_END = 4'b0010,
      SEQ_WAIT_SOF = 4'b0100,
      SEQ_HOLD = 4'b1000
   } vcr_seq_state_type;
   typedef struct packed {
      vcr_seq_state_type st;
      logic [5:0] cnt;
   } vcr_seq_type;
   vcr_seq_type q_reg, q_next;

   assign coreReset = immHold || (q_reg.st == SEQ_HOLD);
   assign resetPending = (q_reg.st == SEQ_WAIT_END) || (q_reg.st == SEQ_WAIT_SOF);

   always_comb begin
      q_next = q_reg;
      unique case (q_reg.st)
         SEQ_IDLE: begin
            q_next.cnt = '0;
            if (immHold) begin
               q_next.st = SEQ_IDLE;
            end else if (autoReq) begin
               q_next.st = inFrame ? SEQ_WAIT_END : SEQ_HOLD;
            end else if (fsyncReq) begin
               q_next.st = SEQ_WAIT_SOF;
            end
         end
         SEQ_WAIT_END: begin
            if (immHold) begin
               q_next.st = SEQ_IDLE;
            end else if (frameEnd) begin
               q_next.st = SEQ_HOLD;
            end
         end
         SEQ_WAIT_SOF: begin
            if (immHold) begin
               q_next.st = SEQ_IDLE;
            end else if (frameStart || frameEnd) begin
               q_next.st = SEQ_HOLD;
            end
         end
         SEQ_HOLD: begin
            if (q_reg.cnt == 6'(RESET_HOLD_CYCLES - 1)) begin
               q_next.st = SEQ_IDLE;
            end else begin
               q_next.cnt = q_reg.cnt + 6'h01;
            end
         end
         default: begin
            q_next.st = SEQ_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q_reg <= '{st: SEQ_IDLE, cnt: '0};
      end else begin
         q_reg <= q_next;
      end
   end

   property p_hold_len;
      @(posedge clk) disable iff (sys_rst)
      $rose(q_reg.st == SEQ_HOLD) |-> ##31 (q_reg.st == SEQ_HOLD) ##1 (q_reg.st != SEQ_HOLD);
   endproperty
   a_hold_len: assert property (p_hold_len) else $error("hold not 32 cycles");

   property p_auto_wait;
      @(posedge clk) disable iff (sys_rst)
      (q_reg.st == SEQ_IDLE && autoReq && inFrame && !immHold) |=> (q_reg.st == SEQ_WAIT_END);
   endproperty
   a_auto_wait: assert property (p_auto_wait) else $error("auto reset not deferred");

   property p_fsync_wait;
      @(posedge clk) disable iff (sys_rst)
      (q_reg.st == SEQ_WAIT_SOF && !frameStart && !frameEnd && !immHold) |=> (q_reg.st != SEQ_HOLD);
   endproperty
   a_fsync_wait: assert property (p_fsync_wait) else $error("frame reset not deferred");
endmodule

// ==== vcr_top.sv ====
// Control and status bank of the pixel-correction core with its stream path.
// Assumes an AXI4-Lite master and AXI4-Stream video peers on the same clock.
//
// Overview of operation
// - Software reset restores registers, flushes FIFO, drops stream valid and ready.
// - Writing control bit 30 resets the core at once, even mid-frame.
// - The core stays in reset while the reset flag remains set.
// - After the flag clears, input is resynchronised to the next frame start.
// - Auto reset waits for frame end if requested mid-frame, then holds reset exactly 32 cycles.
// - Frame-synchronised reset waits for the next frame start or frame end on the input.
// - A stalled frame keeps the frame reset pending until frame completes or restarts.
// - Frame size and algorithm parameters are double-buffered.
// - Writes land in shadow copies; frame start copies them to the active set.
// - The copy happens only while the commit enable flag is one.
// - Register writes update only the bytes enabled by s_axi_wstrb; reads return a full 32-bit word.
// - General registers at 0x0000-0x0020, algorithm at 0x0100, defect count 0x0120.
// - Monitors count frames, lines and pixels since the last reset.
// - Error bits flag short and long lines and early and late frame starts.
// - Input ready stays low during initialisation and flushing.
`timescale 1ns/100ps
module vcr_top #(
   parameter logic [31:0] VERSION_ID = 32'h0001_0000, // Arbitrary value.
   parameter int FIFO_DEPTH = 8
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [11:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [11:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [vcr_pkg::PIX_W-1:0] s_axis_video_tdata,
   input wire logic s_axis_video_tvalid,
   output logic s_axis_video_tready,
   input wire logic s_axis_video_tuser,
   input wire logic s_axis_video_tlast,
   output logic [vcr_pkg::PIX_W-1:0] m_axis_video_tdata,
   output logic m_axis_video_tvalid,
   input wire logic m_axis_video_tready,
   output logic m_axis_video_tuser,
   output logic m_axis_video_tlast,
   output vcr_pkg::vcr_params_type activeParams
);
   import vcr_pkg::*;
   typedef struct packed {
      logic [31:0] ctrl;
      logic [31:0] err;
      logic [31:0] irqMask;
      vcr_params_type sh;
      vcr_params_type ac;
      logic [31:0] frameCnt;
      logic [31:0] lineCnt;
      logic [31:0] pixCnt;
      logic [15:0] colPos;
      logic [15:0] rowPos;
      logic inFrame;
      logic resync;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } vcr_top_state_type;
   vcr_top_state_type q_reg, q_next;

   // ----------------------------------------------------------------
   // Decoding helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
         input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = data[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic thrHit(input logic [11:0] addr);
      return (addr == OFS_TEMPORAL_VARIANCE_THRESHOLD) ||
         (addr == OFS_SPATIAL_VARIANCE_THRESHOLD) || (addr == OFS_PIXEL_AGE_THRESHOLD);
   endfunction

   function automatic logic isMapped(input logic [11:0] addr);
      return (addr[11:2] <= OFS_FRAME_DIMENSIONS[11:2]) || thrHit(addr) ||
         (addr[11:2] == OFS_CANDIDATE_COUNT[11:2]) || (addr[11:2] == OFS_DEFECT_COUNT[11:2]);
   endfunction

   // ----------------------------------------------------------------
   // Stream handshake and frame events
   // ----------------------------------------------------------------
   logic coreReset, resetPending, enable, wEn, rEn, ctrlWrite;
   logic autoReq, fsyncReq, inAcc, pass, frameStart, frameEnd;
   logic fifoInReady, fifoOutValid;
   logic [15:0] cols, rows;
   vcr_beat_type inBeat, outBeat;

   assign enable = q_reg.ctrl[CTRL_ENABLE_BIT];
   assign cols = q_reg.ac.dims[15:0];
   assign rows = q_reg.ac.dims[31:16];
   assign wEn = s_axi_awvalid && s_axi_wvalid && !q_reg.bvalid;
   assign rEn = s_axi_arvalid && !q_reg.rvalid;
   assign s_axi_awready = wEn;
   assign s_axi_wready = wEn;
   assign s_axi_arready = rEn;
   assign ctrlWrite = wEn && (s_axi_awaddr[11:2] == OFS_CORE_CONTROL[11:2]) && s_axi_wstrb[3];
   assign autoReq = ctrlWrite && s_axi_wdata[CTRL_AUTO_RESET_BIT];
   assign fsyncReq = ctrlWrite && s_axi_wdata[CTRL_FSYNC_RESET_BIT];

   assign s_axis_video_tready = enable && !coreReset && fifoInReady;
   assign inAcc = s_axis_video_tvalid && s_axis_video_tready;
   assign pass = inAcc && (!q_reg.resync || s_axis_video_tuser);
   assign frameStart = pass && s_axis_video_tuser;
   assign frameEnd = pass && s_axis_video_tlast && (q_reg.rowPos + 16'h0001 == rows);
   assign inBeat = '{user: s_axis_video_tuser, last: s_axis_video_tlast,
      data: s_axis_video_tdata};

   vcr_reset_seq u_reset_seq (
      .clk(clk),
      .sys_rst(sys_rst),
      .immHold(q_reg.ctrl[CTRL_IMM_RESET_BIT]),
      .autoReq(autoReq),
      .fsyncReq(fsyncReq),
      .frameStart(frameStart),
      .frameEnd(frameEnd),
      .inFrame(q_reg.inFrame),
      .coreReset(coreReset),
      .resetPending(resetPending)
   );

   vcr_fifo #(
      .WIDTH($bits(vcr_beat_type)),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .flush(coreReset),
      .inData(inBeat),
      .inValid(pass),
      .inReady(fifoInReady),
      .outData(outBeat),
      .outValid(fifoOutValid),
      .outReady(m_axis_video_tready && enable && !coreReset)
   );

   assign m_axis_video_tvalid = fifoOutValid && enable && !coreReset;
   assign m_axis_video_tdata = outBeat.data;
   assign m_axis_video_tuser = outBeat.user;
   assign m_axis_video_tlast = outBeat.last;
   assign activeParams = q_reg.ac;
   assign s_axi_bvalid = q_reg.bvalid;
   assign s_axi_bresp = q_reg.bresp;
   assign s_axi_rvalid = q_reg.rvalid;
   assign s_axi_rresp = q_reg.rresp;
   assign s_axi_rdata = q_reg.rdata;

   // ----------------------------------------------------------------
   // Register bank and frame tracking
   // ----------------------------------------------------------------
   always_comb begin
      q_next = q_reg;
      if (coreReset) begin
         q_next.ctrl = CONTROL_RESET;
         q_next.ctrl[CTRL_IMM_RESET_BIT] = q_reg.ctrl[CTRL_IMM_RESET_BIT];
         q_next.err = '0;
         q_next.irqMask = '0;
         q_next.sh = PARAMS_RESET;
         q_next.ac = PARAMS_RESET;
         q_next.frameCnt = '0;
         q_next.lineCnt = '0;
         q_next.pixCnt = '0;
         q_next.colPos = '0;
         q_next.rowPos = '0;
         q_next.inFrame = 1'b0;
         q_next.resync = 1'b1;
      end
      if (q_reg.bvalid && s_axi_bready) begin
         q_next.bvalid = 1'b0;
      end
      if (wEn) begin
         q_next.bvalid = 1'b1;
         q_next.bresp = isMapped(s_axi_awaddr) ? RESP_OKAY : RESP_SLVERR;
         if (s_axi_awaddr[11:2] == OFS_CORE_CONTROL[11:2]) begin
            q_next.ctrl = mergeStrb(q_next.ctrl, s_axi_wdata, s_axi_wstrb);
            q_next.ctrl[CTRL_AUTO_RESET_BIT] = 1'b0;
            q_next.ctrl[CTRL_FSYNC_RESET_BIT] = 1'b0;
         end
         if (s_axi_awaddr[11:2] == OFS_STREAM_ERROR_FLAGS[11:2]) begin
            q_next.err = q_next.err & ~mergeStrb(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
         end
         if (s_axi_awaddr[11:2] == OFS_INTERRUPT_ENABLE_MASK[11:2]) begin
            q_next.irqMask = mergeStrb(q_next.irqMask, s_axi_wdata, s_axi_wstrb);
         end
         if (s_axi_awaddr[11:2] == OFS_FRAME_DIMENSIONS[11:2]) begin
            q_next.sh.dims = mergeStrb(q_next.sh.dims, s_axi_wdata, s_axi_wstrb);
         end
         if (thrHit({s_axi_awaddr[11:2], 2'b00})) begin
            q_next.sh.thr[s_axi_awaddr[3:2]] = mergeStrb(q_next.sh.thr[s_axi_awaddr[3:2]],
               s_axi_wdata, s_axi_wstrb);
         end
      end
      if (!coreReset && pass) begin
         q_next.pixCnt = q_reg.pixCnt + 32'h0000_0001;
         q_next.resync = 1'b0;
         if (s_axis_video_tuser) begin
            q_next.inFrame = 1'b1;
            q_next.rowPos = '0;
            if (q_reg.rowPos != '0 && q_reg.rowPos < rows) begin
               q_next.err[ERR_SOF_EARLY_BIT] = 1'b1;
            end
            if (q_reg.rowPos > rows) begin
               q_next.err[ERR_SOF_LATE_BIT] = 1'b1;
            end
            if (q_reg.ctrl[CTRL_COMMIT_BIT]) begin
               q_next.ac = q_reg.sh;
            end
         end
         if (s_axis_video_tlast) begin
            q_next.colPos = '0;
            q_next.lineCnt = q_reg.lineCnt + 32'h0000_0001;
            q_next.rowPos = (s_axis_video_tuser ? 16'h0000 : q_reg.rowPos) + 16'h0001;
            if (q_reg.colPos + 16'h0001 < cols) begin
               q_next.err[ERR_LINE_SHORT_BIT] = 1'b1;
            end
            if (q_reg.colPos + 16'h0001 > cols) begin
               q_next.err[ERR_LINE_LONG_BIT] = 1'b1;
            end
            if (frameEnd) begin
               q_next.inFrame = 1'b0;
               q_next.frameCnt = q_reg.frameCnt + 32'h0000_0001;
            end
         end else begin
            q_next.colPos = (s_axis_video_tuser ? 16'h0000 : q_reg.colPos) + 16'h0001;
         end
      end
      if (q_reg.rvalid && s_axi_rready) begin
         q_next.rvalid = 1'b0;
      end
      if (rEn) begin
         q_next.rvalid = 1'b1;
         q_next.rresp = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         q_next.rdata = 32'h0000_0000;
         unique case ({s_axi_araddr[11:2], 2'b00})
            OFS_CORE_CONTROL: q_next.rdata = q_reg.ctrl;
            OFS_CORE_STATUS: q_next.rdata = {28'h0000000, resetPending, q_reg.resync,
               q_reg.inFrame, coreReset};
            OFS_STREAM_ERROR_FLAGS: q_next.rdata = q_reg.err;
            OFS_INTERRUPT_ENABLE_MASK: q_next.rdata = q_reg.irqMask;
            OFS_CORE_VERSION_ID: q_next.rdata = VERSION_ID;
            OFS_FRAME_COUNT_MONITOR: q_next.rdata = q_reg.frameCnt;
            OFS_LINE_COUNT_MONITOR: q_next.rdata = q_reg.lineCnt;
            OFS_PIXEL_COUNT_MONITOR: q_next.rdata = q_reg.pixCnt;
            OFS_FRAME_DIMENSIONS: q_next.rdata = q_reg.sh.dims;
            OFS_TEMPORAL_VARIANCE_THRESHOLD: q_next.rdata = q_reg.sh.thr[0];
            OFS_SPATIAL_VARIANCE_THRESHOLD: q_next.rdata = q_reg.sh.thr[1];
            OFS_PIXEL_AGE_THRESHOLD: q_next.rdata = q_reg.sh.thr[2];
            default: q_next.rdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         q_reg <= '0;
         q_reg.ctrl <= CONTROL_RESET;
         q_reg.sh <= PARAMS_RESET;
         q_reg.ac <= PARAMS_RESET;
         q_reg.resync <= 1'b1;
      end else begin
         q_reg <= q_next;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   property p_reset_quiet;
      @(posedge clk) disable iff (sys_rst)
      coreReset |-> (!s_axis_video_tready && !m_axis_video_tvalid);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("stream active in reset");

   property p_imm_reset;
      @(posedge clk) disable iff (sys_rst)
      (ctrlWrite && s_axi_wdata[CTRL_IMM_RESET_BIT]) |=> coreReset;
   endproperty
   a_imm_reset: assert property (p_imm_reset) else $error("immediate reset missed");

   property p_held;
      @(posedge clk) disable iff (sys_rst)
      q_reg.ctrl[CTRL_IMM_RESET_BIT] |=> (q_reg.pixCnt == '0) && q_reg.resync;
   endproperty
   a_held: assert property (p_held) else $error("reset released while flag set");

   property p_commit;
      @(posedge clk) disable iff (sys_rst)
      (frameStart && q_reg.ctrl[CTRL_COMMIT_BIT] && !coreReset) |=> (q_reg.ac == $past(q_reg.sh));
   endproperty
   a_commit: assert property (p_commit) else $error("shadow not committed");

   property p_no_commit;
      @(posedge clk) disable iff (sys_rst)
      (!q_reg.ctrl[CTRL_COMMIT_BIT] && !coreReset) ##1 !coreReset |-> $stable(q_reg.ac);
   endproperty
   a_no_commit: assert property (p_no_commit) else $error("active set changed");

   property p_line_short;
      @(posedge clk) disable iff (sys_rst)
      (pass && !coreReset && s_axis_video_tlast && !s_axis_video_tuser &&
         (q_reg.colPos + 16'h0001 < cols)) |=> q_reg.err[ERR_LINE_SHORT_BIT];
   endproperty
   a_line_short: assert property (p_line_short) else $error("short line not flagged");

   property p_resync_drop;
      @(posedge clk) disable iff (sys_rst)
      (q_reg.resync && inAcc && !s_axis_video_tuser) |-> !pass;
   endproperty
   a_resync_drop: assert property (p_resync_drop) else $error("beat passed before sync");

   property p_disabled;
      @(posedge clk) disable iff (sys_rst)
      !enable |-> ##[0:1] (!s_axis_video_tready && !m_axis_video_tvalid);
   endproperty
   a_disabled: assert property (p_disabled) else $error("stream active while disabled");
endmodule

// ==== vcr_video_src.sv ====
// Upstream video source model: one frame of rows by columns beats per go pulse.
// Assumes the core settles its ready output before the falling clock edge.
`timescale 1ns/100ps
module vcr_video_src (
   input wire logic clk,
   input wire logic go,
   input wire logic [31:0] frameDims,
   input wire logic s_axis_video_tready,
   output logic [vcr_pkg::PIX_W-1:0] s_axis_video_tdata,
   output logic s_axis_video_tvalid,
   output logic s_axis_video_tuser,
   output logic s_axis_video_tlast,
   output logic busy,
   output logic stall
);
   import vcr_pkg::*;
   int n;
   integer seed = 32'h83005d3a;
   initial begin
      {s_axis_video_tvalid, s_axis_video_tuser, s_axis_video_tlast, busy, stall} = '0;
      s_axis_video_tdata = '0;
      forever begin
         @(posedge clk);
         busy = go;
         #1;
         for (int i = 0; busy && i < frameDims[31:16] * frameDims[15:0]; i++) begin
            s_axis_video_tuser = (i == 0);
            s_axis_video_tlast = ((i + 1) % frameDims[15:0] == 0);
            s_axis_video_tdata = PIX_W'($random(seed));
            s_axis_video_tvalid = 1;
            n = 0;
            do @(negedge clk); while (s_axis_video_tready !== 1'b1 && ++n < 200);
            stall = stall || (n >= 200);
            @(posedge clk);
            #1;
            if ($random(seed) % 3 == 0) begin
               // Released data is inverted so that a stale beat never looks valid.
               s_axis_video_tdata = ~s_axis_video_tdata;
               s_axis_video_tvalid = 0;
               @(posedge clk);
               #1;
            end
         end
         s_axis_video_tvalid = 0;
         busy = 0;
      end
   end
endmodule

// ==== tb_top.sv ====
// Self-checking bench of the control bank and its stream path.
// Assumes the source model and a downstream sink that stalls at random.
`timescale 1ns/100ps
module tb_top;
   import vcr_pkg::*;
   logic clk = 0, sys_rst = 1, go = 0, hold = 0, busy, stall, track = 1, m_axis_video_tready = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, rData, thr, s_axi_rdata, frameDims = 32'h0002_0008;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [PIX_W-1:0] s_axis_video_tdata, m_axis_video_tdata;
   logic s_axis_video_tvalid, s_axis_video_tready, s_axis_video_tuser, s_axis_video_tlast;
   logic m_axis_video_tvalid, m_axis_video_tuser, m_axis_video_tlast;
   vcr_params_type activeParams;
   int err_total = 0, tests_run = 0, outCnt = 0, inCnt = 0, frames = 0, n;
   logic [PIX_W+1:0] sb [0:127];
   integer seed = 32'h83005d3a;
   vcr_top vcr_top_i (.*, .s_axi_wstrb(4'hf), .s_axi_bready(1'b1), .s_axi_rready(1'b1));
   vcr_video_src vcr_video_src_i (.*);
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) m_axis_video_tready <= #1 !hold && 1'($random(seed));
   always @(negedge clk) begin
      if (s_axis_video_tvalid === 1'b1 && s_axis_video_tready === 1'b1 && track) begin
         sb[inCnt] = {s_axis_video_tuser, s_axis_video_tlast, s_axis_video_tdata};
         inCnt++;
      end
      if (m_axis_video_tvalid === 1'b1 && m_axis_video_tready) begin
         chk({m_axis_video_tuser, m_axis_video_tlast, m_axis_video_tdata}, sb[outCnt]);
         outCnt++;
      end
   end
   task automatic final_report;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
         err_total++;
      end
   endtask
   task automatic bound(input bit hit);
      if (hit) begin
         $display("[ERR] %0t wait timed out", $time);
         err_total++;
         final_report();
      end
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      #1 {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, n} = {a, d, 2'b11, 32'd0};
      do @(negedge clk); while (s_axi_awready !== 1'b1 && ++n < 200);
      bound(n >= 200);
      @(posedge clk);
      #1 {s_axi_awvalid, s_axi_wvalid} = 2'b00;
   endtask
   task automatic rd(input logic [11:0] a);
      @(posedge clk);
      #1 {s_axi_araddr, s_axi_arvalid, n} = {a, 1'b1, 32'd0};
      do @(negedge clk); while (s_axi_arready !== 1'b1 && ++n < 200);
      bound(n >= 200);
      @(posedge clk);
      #1 s_axi_arvalid = 0;
      rData = s_axi_rdata;
   endtask
   // Mode 1 stalls the sink to fill the buffer; mode 2 expects a frame reset.
   task automatic frame(input int mode);
      track = (mode < 2);
      go = 1;
      @(posedge clk);
      #1 go = 0;
      hold = (mode == 1);
      repeat (40) @(posedge clk);
      #1;
      if (mode == 1) chk(s_axis_video_tready, 0);
      hold = 0;
      if (mode == 2) begin
         rd(OFS_CORE_STATUS);
         chk(rData[3], 0);
         wr(OFS_CORE_CONTROL, 32'h3);
      end
      n = 0;
      do @(posedge clk); while (busy !== 1'b0 && ++n < 900);
      bound(n >= 900 || stall);
      repeat (30) @(posedge clk);
      #1;
      frames += (mode < 2);
      chk(outCnt, 16 * frames);
   endtask
   initial begin
      repeat (20) @(posedge clk);
      #1 sys_rst = 0;
      rd(OFS_CORE_CONTROL);
      chk(rData, CONTROL_RESET);
      rd(OFS_CORE_VERSION_ID);
      chk(rData, 32'h0001_0000);
      rd(12'h200);
      chk(s_axi_rresp, RESP_SLVERR);
      wr(12'h200, 32'h0000_0000);
      chk(s_axi_bresp, RESP_SLVERR);
      wr(OFS_FRAME_DIMENSIONS, frameDims);
      wr(OFS_CORE_CONTROL, 32'h3);
      frame(1);
      chk(activeParams.dims, frameDims);
      thr = $random(seed);
      wr(OFS_CORE_CONTROL, 32'h1);
      wr(OFS_TEMPORAL_VARIANCE_THRESHOLD, thr);
      rd(OFS_TEMPORAL_VARIANCE_THRESHOLD);
      chk(rData, thr);
      frame(0);
      chk(activeParams.thr[0], THRESHOLD_RESET);
      wr(OFS_CORE_CONTROL, 32'h3);
      frame(0);
      chk(activeParams.thr[0], thr);
      wr(OFS_FRAME_DIMENSIONS, frameDims + 1);
      frame(0);
      rd(OFS_STREAM_ERROR_FLAGS);
      chk(rData[3:0], 4'h1);
      wr(OFS_CORE_CONTROL, 32'h4000_0003);
      repeat (40) @(posedge clk);
      rd(OFS_CORE_STATUS);
      chk(rData[0], 1);
      chk(s_axis_video_tready, 0);
      rd(OFS_TEMPORAL_VARIANCE_THRESHOLD);
      chk(rData, THRESHOLD_RESET);
      wr(OFS_CORE_CONTROL, 32'h3);
      wr(OFS_FRAME_DIMENSIONS, frameDims);
      chk(s_axis_video_tready, 1);
      frame(0);
      rd(OFS_PIXEL_COUNT_MONITOR);
      chk(rData, 16);
      rd(OFS_LINE_COUNT_MONITOR);
      chk(rData, 2);
      wr(OFS_CORE_CONTROL, 32'h8000_0003);
      rd(OFS_CORE_STATUS);
      chk(rData[0], 1);
      repeat (40) @(posedge clk);
      rd(OFS_CORE_CONTROL);
      chk(rData, CONTROL_RESET);
      wr(OFS_CORE_CONTROL, 32'h2000_0003);
      repeat (40) @(posedge clk);
      rd(OFS_CORE_STATUS);
      chk({rData[3], rData[0]}, 2'b10);
      frame(2);
      final_report();
   end
endmodule
